// ==== inc/dps_pkg.sv ====
package dps_pkg;
	// Clock and timing
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	localparam int PG_MS = 3;
	localparam int PG_CYCLES = PG_MS * (CLK_HZ / 1000);
	localparam int MIN_OFF_NS = 400;
	localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
	localparam int FAST_SHIFT = 2;
	// Widths
	localparam int TW = 6;
	localparam int IRQ_W = 3;
	// Register offsets
	localparam logic [7:0] A_SLEW = 8'h00;
	localparam logic [7:0] A_TON = 8'h04;
	localparam logic [7:0] A_PER = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_ISR = 8'h10;
	localparam logic [7:0] A_IMR = 8'h14;
	// Reset values
	localparam logic [15:0] SLEW_RST = 16'h0064;
	localparam logic [11:0] TON_RST = 12'h0C8;
	localparam logic [15:0] PER_RST = 16'h03E8;
	// Code to target step bases
	localparam logic [TW-1:0] VID_BASE = 6'h1B;
	localparam logic [TW-1:0] SUS_BASE = 6'h10;
	// Interrupt bits
	localparam int IRQ_PG = 0;
	localparam int IRQ_OVL = 1;
	localparam int IRQ_OFF = 2;
	// Bus responses
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// Sequencer states
	typedef enum logic [2:0] {
		SQ_OFF = 3'b000,
		SQ_REF = 3'b001,
		SQ_RAMP = 3'b010,
		SQ_PGW = 3'b011,
		SQ_RUN = 3'b100,
		SQ_SHUT = 3'b101
	} dps_seq_e;
	// Phase scheduler states
	typedef enum logic [1:0] {
		PH_WAIT = 2'b00,
		PH_ON = 2'b01,
		PH_OFF = 2'b10
	} dps_ph_e;
endpackage : dps_pkg

// ==== inc/dps_ph_if.sv ====
`timescale 1ns/1ns
interface dps_ph_if;
	logic run;
	logic skip;
	logic above;
	logic [11:0] ton;
	logic [15:0] half;
	logic dh_m;
	logic dh_s;
	logic dl_m;
	logic dl_s;
	logic ovl;
	modport ctl (output run, skip, above, ton, half, input dh_m, dh_s, dl_m, dl_s, ovl);
	modport ph (input run, skip, above, ton, half, output dh_m, dh_s, dl_m, dl_s, ovl);
endinterface : dps_ph_if

// ==== hdl/dps_slew.sv ====
`timescale 1ns/1ns
module dps_slew (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic [15:0] div,
	input wire logic fast,
	input wire logic [dps_pkg::TW-1:0] goal,
	// Status
	output logic [dps_pkg::TW-1:0] target,
	output logic at_goal
);
	import dps_pkg::*;
	logic [15:0] cnt_q, cnt_d;
	logic [TW-1:0] tgt_q, tgt_d;
	logic [15:0] per;
	logic tick;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////
	// Tick divider, divide value quartered (shifted right by two) while shutting down
	always_comb begin
		per = fast ? (div >> FAST_SHIFT) : div;
		tick = (cnt_q >= per);
		cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
		tgt_d = tgt_q;
		if (tick && tgt_q < goal) begin
			tgt_d = tgt_q + 6'h01;
		end else if (tick && tgt_q > goal) begin
			tgt_d = tgt_q - 6'h01;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 16'h0000;
			tgt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
			tgt_q <= tgt_d;
		end
	end

	assign target = tgt_q;
	assign at_goal = (tgt_q == goal);

	////////////////////////////////////////////////////////////////
	// Checks
	AST_ONE_STEP_ON_TICK: assert property ((tgt_q != $past(tgt_q)) |->
		($past(tick) && (tgt_q == $past(tgt_q) + 6'h01 || tgt_q == $past(tgt_q) - 6'h01)))
		else $error("target moved without tick or by more than one step");
	AST_RAMP_UP: assert property ((tick && tgt_q < goal) |=> (tgt_q == $past(tgt_q) + 6'h01))
		else $error("ramp did not step up on tick");
	COV_TICK: cover property (tick ##1 !tick);
endmodule : dps_slew

// ==== hdl/dps_phase.sv ====
`timescale 1ns/1ns
module dps_phase (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Controller side
	dps_ph_if.ph p
);
	import dps_pkg::*;
	dps_ph_e st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] slot_q, slot_d;
	logic both_q, both_d;
	logic sel_q, sel_d;
	logic last_q, last_d;
	logic ovl_q, ovl_d;
	logic dhm_q, dhm_d;
	logic dhs_q, dhs_d;
	logic off_end;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////
	// Pulse scheduling; sel is the next single phase, 1 = secondary
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		both_d = both_q;
		sel_d = sel_q;
		last_d = last_q;
		ovl_d = ovl_q;
		off_end = (st_q == PH_OFF) && (cnt_q <= 16'h0001);
		slot_d = (slot_q == 16'hFFFF) ? slot_q : slot_q + 16'h0001;
		case (st_q)
			PH_WAIT: begin
				// Half-period slot; skip mode waits for output to sag
				if (slot_q >= p.half && !(p.skip && p.above)) begin
					st_d = PH_ON;
					cnt_d = {4'h0, p.ton};
					both_d = 1'b0;
					last_d = sel_q;
					sel_d = ~sel_q;
					slot_d = 16'h0000;
				end
			end
			PH_ON: begin
				if (cnt_q <= 16'h0001) begin
					st_d = PH_OFF;
					cnt_d = 16'(MIN_OFF_CYC);
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			PH_OFF: begin
				if (!off_end) begin
					cnt_d = cnt_q - 16'h0001;
				end else if (!p.above) begin
					st_d = PH_ON;
					cnt_d = {4'h0, p.ton};
					both_d = 1'b1;
					ovl_d = 1'b1;
				end else begin
					st_d = PH_WAIT;
					if (ovl_q) begin
						ovl_d = 1'b0;
						sel_d = ~last_q;
					end
				end
			end
			default: st_d = PH_WAIT;
		endcase
		if (!p.run) begin
			st_d = PH_WAIT;
			both_d = 1'b0;
			ovl_d = 1'b0;
		end
		dhm_d = (st_d == PH_ON) && (both_d || !last_d);
		dhs_d = (st_d == PH_ON) && (both_d || last_d);
	end

	// State registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= PH_WAIT;
			cnt_q <= 16'h0000;
			slot_q <= 16'h0000;
			both_q <= 1'b0;
			sel_q <= 1'b0;
			last_q <= 1'b1;
			ovl_q <= 1'b0;
			dhm_q <= 1'b0;
			dhs_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			slot_q <= slot_d;
			both_q <= both_d;
			sel_q <= sel_d;
			last_q <= last_d;
			ovl_q <= ovl_d;
			dhm_q <= dhm_d;
			dhs_q <= dhs_d;
		end
	end

	// Low sides are the complement; both high while idle
	assign p.dh_m = dhm_q;
	assign p.dh_s = dhs_q;
	assign p.dl_m = ~dhm_q;
	assign p.dl_s = ~dhs_q;
	assign p.ovl = ovl_q;

	////////////////////////////////////////////////////////////////
	// Checks
	AST_NO_DUAL_HIGH_SIDE: assert property ((dhm_q && dhs_q) |-> ovl_q)
		else $error("both high sides on outside overlap");
	AST_OVERLAP_ENTRY: assert property ((off_end && !p.above && p.run) |=> (dhm_q && dhs_q && ovl_q))
		else $error("overlap pulse missing after low output");
	AST_OVERLAP_HOLD: assert property ((ovl_q && p.run && !(off_end && p.above)) |=> ovl_q)
		else $error("overlap ended without output above regulation");
	AST_RESUME_OPPOSITE: assert property ((ovl_q && off_end && p.above && p.run) |=>
		(!ovl_q && sel_q == !$past(last_q)))
		else $error("interleave not resumed on opposite phase");
	AST_INTERLEAVE: assert property ((st_q == PH_WAIT && st_d == PH_ON && p.run) |->
		(slot_q >= p.half) ##1 (last_q != $past(last_q) && (dhm_q ^ dhs_q)))
		else $error("single pulse off slot or not alternating");
	AST_SKIP_HOLD: assert property ((st_q == PH_WAIT && p.skip && p.above) |=> !(dhm_q || dhs_q))
		else $error("pulse issued while skipping above regulation");
	COV_OVERLAP_EXIT: cover property (ovl_q ##1 !ovl_q);
endmodule : dps_phase

// ==== hdl/dps_top.sv ====
`timescale 1ns/1ns
module dps_top #(
	parameter int PG_CYC = dps_pkg::PG_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins in
	input wire logic shutdown_n_input,
	input wire logic skip_sel,
	input wire logic suspend_sel,
	input wire logic [4:0] vid_code_inputs,
	input wire logic [3:0] suspend_code_inputs,
	input wire logic ref_ok,
	input wire logic out_above_reg,
	// Pins out
	output logic ref_enable,
	output logic dh_main,
	output logic dh_sec,
	output logic dl_main,
	output logic dl_sec,
	output logic regulator_power_good,
	output logic irq
);
	import dps_pkg::*;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [13:0] sy1_q;
	logic [13:0] sy2_q;
	logic shutdown_n_input_s, skip_s, sus_s, ref_s, above_s;
	logic [4:0] vid_s;
	logic [3:0] susc_s;

	// Two flops ahead of any logic
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sy1_q <= 14'h0000;
			sy2_q <= 14'h0000;
		end else begin
			sy1_q <= {shutdown_n_input, skip_sel, suspend_sel, vid_code_inputs,
				suspend_code_inputs, ref_ok, out_above_reg};
			sy2_q <= sy1_q;
		end
	end

	assign {shutdown_n_input_s, skip_s, sus_s, vid_s, susc_s, ref_s, above_s} = sy2_q;

	////////////////////////////////////////////////////////////////
	// Sequencer
	dps_seq_e seq_q, seq_d;
	logic [31:0] pgc_q, pgc_d;
	logic [TW-1:0] goal_q, goal_d;
	logic pg_q, pg_d;
	logic ref_q, ref_d;
	logic [TW-1:0] sel_code;
	logic [TW-1:0] target;
	logic at_goal;

	// Power-up, hold-off and shutdown sequence
	always_comb begin
		seq_d = seq_q;
		pgc_d = pgc_q;
		goal_d = goal_q;
		pg_d = pg_q;
		sel_code = sus_s ? SUS_BASE + {2'h0, susc_s} : VID_BASE + {1'h0, vid_s};
		case (seq_q)
			SQ_OFF: begin
				if (shutdown_n_input_s) begin
					seq_d = SQ_REF;
				end
			end
			SQ_REF: begin
				if (ref_s) begin
					seq_d = SQ_RAMP;
					goal_d = sel_code;
				end
			end
			SQ_RAMP: begin
				goal_d = sel_code;
				if (at_goal) begin
					seq_d = SQ_PGW;
					pgc_d = 32'h0000_0000;
				end
			end
			SQ_PGW: begin
				goal_d = sel_code;
				if (!at_goal) begin
					pgc_d = 32'h0000_0000;
				end else if (pgc_q >= 32'(PG_CYC - 1)) begin
					seq_d = SQ_RUN;
					pg_d = 1'b1;
				end else begin
					pgc_d = pgc_q + 32'h0000_0001;
				end
			end
			SQ_RUN: goal_d = sel_code;
			SQ_SHUT: begin
				goal_d = {TW{1'b0}};
				if (at_goal) begin
					seq_d = SQ_OFF;
				end
			end
			default: seq_d = SQ_OFF;
		endcase
		if (!shutdown_n_input_s && seq_q != SQ_OFF && seq_q != SQ_SHUT) begin
			seq_d = SQ_SHUT;
			goal_d = {TW{1'b0}};
			pg_d = 1'b0;
		end
		ref_d = (seq_d != SQ_OFF);
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seq_q <= SQ_OFF;
			pgc_q <= 32'h0000_0000;
			goal_q <= {TW{1'b0}};
			pg_q <= 1'b0;
			ref_q <= 1'b0;
		end else begin
			seq_q <= seq_d;
			pgc_q <= pgc_d;
			goal_q <= goal_d;
			pg_q <= pg_d;
			ref_q <= ref_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Slew ramp and phase scheduler
	logic [15:0] slew_q, slew_d;
	logic [11:0] ton_q, ton_d;
	logic [15:0] per_q, per_d;
	dps_ph_if ph ();

	dps_slew u_slew (
		.clk(clk),
		.reset_n(reset_n),
		.div(slew_q),
		.fast(seq_q == SQ_SHUT),
		.goal(goal_q),
		.target(target),
		.at_goal(at_goal)
	);

	// Switching from reference-ready until the target is back at zero
	assign ph.run = (seq_q == SQ_RAMP || seq_q == SQ_PGW || seq_q == SQ_RUN)
		|| (seq_q == SQ_SHUT && target != {TW{1'b0}});
	assign ph.skip = ~skip_s;
	assign ph.above = above_s;
	assign ph.ton = ton_q;
	assign ph.half = per_q >> 1;

	dps_phase u_phase (
		.clk(clk),
		.reset_n(reset_n),
		.p(ph)
	);

	////////////////////////////////////////////////////////////////
	// Register bus
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [IRQ_W-1:0] isr_q, isr_d;
	logic [IRQ_W-1:0] imr_q, imr_d;
	logic irq_q, irq_d;
	logic ovl_p_q;
	logic do_wr;
	logic [31:0] m;
	logic [IRQ_W-1:0] ev;

	// Address decode, shared by read and write
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == A_SLEW) || (a == A_TON) || (a == A_PER)
			|| (a == A_STAT) || (a == A_ISR) || (a == A_IMR);
	endfunction : mapped

	// Bus channels, registers and interrupt status
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		slew_d = slew_q;
		ton_d = ton_q;
		per_d = per_q;
		imr_d = imr_q;
		m = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
		do_wr = aw_have_q && w_have_q && !bvalid_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// Hardware events set; set wins over write-one clear
		ev[IRQ_PG] = pg_d && !pg_q;
		ev[IRQ_OVL] = ph.ovl && !ovl_p_q;
		ev[IRQ_OFF] = (seq_q == SQ_SHUT) && (seq_d == SQ_OFF);
		isr_d = isr_q;
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped(awaddr_q) ? RESP_OK : RESP_ERR;
			case (awaddr_q)
				A_SLEW: slew_d = (slew_q & ~m[15:0]) | (wdata_q[15:0] & m[15:0]);
				A_TON: ton_d = (ton_q & ~m[11:0]) | (wdata_q[11:0] & m[11:0]);
				A_PER: per_d = (per_q & ~m[15:0]) | (wdata_q[15:0] & m[15:0]);
				A_ISR: isr_d = isr_q & ~(wdata_q[IRQ_W-1:0] & m[IRQ_W-1:0]);
				A_IMR: imr_d = (imr_q & ~m[IRQ_W-1:0]) | (wdata_q[IRQ_W-1:0] & m[IRQ_W-1:0]);
				default: bresp_d = bresp_d;
			endcase
		end
		isr_d = isr_d | ev;
		irq_d = |(isr_d & imr_d);
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
			case (s_axi_araddr)
				A_SLEW: rdata_d = {16'h0000, slew_q};
				A_TON: rdata_d = {20'h00000, ton_q};
				A_PER: rdata_d = {16'h0000, per_q};
				A_STAT: rdata_d = {16'h0000, 2'h0, target, seq_q, ref_q, ph.ovl, pg_q, above_s, shutdown_n_input_s};
				A_ISR: rdata_d = {29'h00000000, isr_q};
				A_IMR: rdata_d = {29'h00000000, imr_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Bus and register flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OK;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OK;
			slew_q <= SLEW_RST;
			ton_q <= TON_RST;
			per_q <= PER_RST;
			isr_q <= 3'h0;
			imr_q <= 3'h0;
			irq_q <= 1'b0;
			ovl_p_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			slew_q <= slew_d;
			ton_q <= ton_d;
			per_q <= per_d;
			isr_q <= isr_d;
			imr_q <= imr_d;
			irq_q <= irq_d;
			ovl_p_q <= ph.ovl;
		end
	end

	// Outputs
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign ref_enable = ref_q;
	assign regulator_power_good = pg_q;
	assign dh_main = ph.dh_m;
	assign dh_sec = ph.dh_s;
	assign dl_main = ph.dl_m;
	assign dl_sec = ph.dl_s;
	assign irq = irq_q;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_REF_BEFORE_SWITCH: assert property (ph.run |-> ref_q)
		else $error("switching without reference enabled");
	AST_START_ON_REF_OK: assert property ((seq_q == SQ_REF && ref_s && shutdown_n_input_s) |=>
		(seq_q == SQ_RAMP && goal_q == $past(sel_code) && ph.run))
		else $error("reference ready but switching not started");
	AST_PG_HOLD_TIME: assert property ($rose(pg_q) |->
		($past(seq_q) == SQ_PGW && $past(pgc_q) >= 32'(PG_CYC - 1) && at_goal))
		else $error("power good rose before hold time");
	AST_SHUTDOWN_N_INPUT_DROPS_PG: assert property ((!shutdown_n_input_s && seq_q != SQ_OFF) |=> (!pg_q && goal_q == 6'h00))
		else $error("shutdown did not drop power good and target goal");
	AST_IRQ_LEVEL: assert property ((|(isr_q & imr_q)) |-> irq_q)
		else $error("interrupt low with unmasked status set");
	COV_PG_RISE: cover property ($rose(pg_q));
	COV_SHUT_DONE: cover property (seq_q == SQ_SHUT ##1 seq_q == SQ_OFF);
endmodule : dps_top

// ==== dv/dps_far_model.sv ====
`timescale 1ns/1ns
// Reference supply and output comparator beside the block
module dps_far_model #(
	parameter int REF_DLY = 8
) (
	// Clock
	input wire logic clk,
	// From the block
	input wire logic ref_enable,
	// Load control from the bench
	input wire logic heavy,
	// To the block
	output logic ref_ok = 1'b0,
	output logic out_above_reg
);
	int cnt = 0;
	////////////////////////////////////////////////////////////
	// Reference settles some cycles after enable, drops at once
	always @(posedge clk) begin
		cnt <= ref_enable ? ((cnt < REF_DLY) ? cnt + 1 : cnt) : 0;
		ref_ok <= ref_enable && (cnt >= REF_DLY);
	end
	// Output sags below regulation under heavy load
	assign out_above_reg = !heavy;
endmodule : dps_far_model

// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb;
	import dps_pkg::*;
	localparam int PG = 20;
	localparam int SLEW_V = 8;
	localparam int HALF = 40;
	localparam int LIMIT = 20000;
	logic clk = 1'b0, reset_n = 1'b0, heavy = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, suspend_code_inputs = 4'h3;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic shutdown_n_input = 1'b0, skip_sel = 1'b1, suspend_sel = 1'b0, ref_ok, out_above_reg;
	logic [4:0] vid_code_inputs = 5'h05;
	logic ref_enable, dh_main, dh_sec, dl_main, dl_sec, regulator_power_good, irq;
	logic pm = 1'b0, ps = 1'b0, last_sec = 1'b0, pre;
	int failures = 0, samples_checked = 0, cycles = 0, nm = 0, ns = 0, nb = 0, nbc = 0, alt = 0, short_gap = 0, gap = 0;
	int b[6];

	dps_top #(.PG_CYC(PG)) dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .shutdown_n_input(shutdown_n_input), .skip_sel(skip_sel),
		.suspend_sel(suspend_sel), .vid_code_inputs(vid_code_inputs), .suspend_code_inputs(suspend_code_inputs),
		.ref_ok(ref_ok), .out_above_reg(out_above_reg), .ref_enable(ref_enable), .dh_main(dh_main),
		.dh_sec(dh_sec), .dl_main(dl_main), .dl_sec(dl_sec), .regulator_power_good(regulator_power_good),
		.irq(irq));
	dps_far_model far (.clk(clk), .ref_enable(ref_enable), .heavy(heavy), .ref_ok(ref_ok),
		.out_above_reg(out_above_reg));

	////////////////////////////////////////////////////////////
	// Clock
	initial begin
		forever #10 clk = ~clk;
	end
	// Pulse monitor and watchdog
	always @(posedge clk) begin
		cycles <= cycles + 1;
		pm <= dh_main;
		ps <= dh_sec;
		gap <= gap + 1;
		nbc <= nbc + int'(dh_main && dh_sec);
		if (dh_main && !pm && dh_sec && !ps) begin
			nb <= nb + 1;
		end else if ((dh_main && !pm) || (dh_sec && !ps)) begin
			alt <= alt + int'((dh_sec && !ps) == last_sec);
			short_gap <= short_gap + int'(gap < HALF);
			last_sec <= dh_sec && !ps;
			gap <= 0;
			nm <= nm + int'(dh_main && !pm);
			ns <= ns + int'(dh_sec && !ps);
		end
		if (cycles == LIMIT) begin
			failures++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////
	// Compare, bus tasks and sequences
	function automatic int tot();
		return nm + ns + nb;
	endfunction : tot
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Wait for the response; only the watchdog ends a hang
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, e);
		chk(s_axi_rresp, er);
	endtask : rd
	// Enable, then measure ramp plus power good hold
	task power_up(input logic sus, input logic [TW-1:0] goal);
		int t0, g;
		g = int'(goal);
		suspend_sel <= sus;
		b[0] = tot();
		shutdown_n_input <= 1'b1;
		while (ref_ok !== 1'b1) @(posedge clk);
		chk(ref_enable, 1);
		chk(tot() - b[0], 0);
		t0 = cycles;
		while (regulator_power_good !== 1'b1) @(posedge clk);
		chk((cycles - t0 >= (g - 1) * (SLEW_V + 1) + PG) && (cycles - t0 <= (g + 1) * (SLEW_V + 1) + PG + 12), 1);
		chk(tot() > b[0], 1);
		wr(A_STAT, 32'hFFFF_FFFF, RESP_OK);
		rd(A_STAT, {18'h0, goal, 8'h00}, 32'h0000_3F00, RESP_OK);
	endtask : power_up
	// Disable and follow the soft ramp down
	task shut_down(input logic [TW-1:0] goal);
		int t0;
		shutdown_n_input <= 1'b0;
		repeat (4) @(posedge clk);
		chk(regulator_power_good, 0);
		t0 = cycles;
		while (ref_enable !== 1'b0) @(posedge clk);
		chk(cycles - t0 >= (int'(goal) - 1) * (SLEW_V / 4 + 1), 1);
		chk({dh_main, dh_sec, dl_main, dl_sec}, 4'h3);
		rd(A_ISR, 32'h4, 32'h4, RESP_OK);
	endtask : shut_down
	task conclude();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rd(A_SLEW, {16'h0, SLEW_RST}, 32'hFFFF_FFFF, RESP_OK);
		rd(A_TON, {20'h0, TON_RST}, 32'hFFFF_FFFF, RESP_OK);
		rd(A_PER, {16'h0, PER_RST}, 32'hFFFF_FFFF, RESP_OK);
		rd(A_IMR, 32'h0, 32'hFFFF_FFFF, RESP_OK);
		rd(8'h40, 32'h0, 32'h0, RESP_ERR);
		wr(8'h40, 32'h1, RESP_ERR);
		wr(A_SLEW, SLEW_V, RESP_OK);
		wr(A_TON, 32'h4, RESP_OK);
		wr(A_PER, 2 * HALF, RESP_OK);
		wr(A_IMR, 32'h1, RESP_OK);
		power_up(1'b1, SUS_BASE + {2'b00, suspend_code_inputs});
		chk(irq, 1);
		wr(A_ISR, 32'h1, RESP_OK);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		shut_down(SUS_BASE + {2'b00, suspend_code_inputs});
		power_up(1'b0, VID_BASE + {1'b0, vid_code_inputs});
		// Interleaved window
		b = '{nm, ns, nb, nbc, alt, short_gap};
		repeat (400) @(posedge clk);
		chk(nb - b[2], 0);
		chk(nbc - b[3], 0);
		chk((nm - b[0] >= 4) && (ns - b[1] >= 4), 1);
		chk(alt - b[4], 0);
		chk(short_gap - b[5], 0);
		// Heavy load gives overlap
		wr(A_IMR, 32'h2, RESP_OK);
		heavy <= 1'b1;
		while (nb == b[2]) @(posedge clk);
		pre = last_sec;
		b = '{nm, ns, nb, nbc, alt, short_gap};
		repeat (200) @(posedge clk);
		chk(nm + ns - b[0] - b[1], 0);
		chk(nb - b[2] >= 2, 1);
		chk(irq, 1);
		wr(A_IMR, 32'h0, RESP_OK);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		heavy <= 1'b0;
		b = '{nm, ns, nb, nbc, alt, short_gap};
		while (nm + ns == b[0] + b[1]) @(posedge clk);
		chk(last_sec, !pre);
		wr(A_ISR, 32'h7, RESP_OK);
		rd(A_ISR, 32'h0, 32'h7, RESP_OK);
		// Skip select low with output above
		skip_sel <= 1'b0;
		repeat (60) @(posedge clk);
		b[0] = tot();
		repeat (300) @(posedge clk);
		chk(tot() - b[0], 0);
		skip_sel <= 1'b1;
		shut_down(VID_BASE + {1'b0, vid_code_inputs});
		conclude();
	end
endmodule : tb
